// File: common/varb_consts.vh
// Constants for the four-level bus arbiter and bus timer
`ifndef VARB_CONSTS_VH
`define VARB_CONSTS_VH
// Arbitration mode codes (arbitrationTypeConfig)
`define VARB_MODE_FIXED 2'h0
`define VARB_MODE_ROTATE 2'h1
`define VARB_MODE_TOPROT 2'h2
`define VARB_MODE_DEFAULT 2'h2
// Clock rate in MHz
`define VARB_CLK_MHZ 250
// Interrupt acknowledge timeouts in microseconds
`define VARB_IACK_LONG_US 128
`define VARB_IACK_SHORT_US 32
`define VARB_IACK_LONG_CYC (`VARB_IACK_LONG_US * `VARB_CLK_MHZ)
`define VARB_IACK_SHORT_CYC (`VARB_IACK_SHORT_US * `VARB_CLK_MHZ)
// Transfer timeouts in microseconds, select codes 0..7
`define VARB_XFER_US0 8
`define VARB_XFER_US1 16
`define VARB_XFER_US2 32
`define VARB_XFER_US3 64
`define VARB_XFER_US4 128
`define VARB_XFER_US5 256
`define VARB_XFER_US6 512
`define VARB_XFER_US7 1024
// Counter width for timeout counts
`define VARB_TMR_W 20
`endif

// File: verilog/varb_bus_timer.v
// Bus timer: drives bus error when a slave fails to acknowledge in time
`timescale 1ns/10ps
`default_nettype none
`include "varb_consts.vh"
module varb_bus_timer #(
  parameter integer CLK_MHZ = `VARB_CLK_MHZ,
  parameter integer XFER_US0 = `VARB_XFER_US0,
  parameter integer XFER_US1 = `VARB_XFER_US1,
  parameter integer XFER_US2 = `VARB_XFER_US2,
  parameter integer XFER_US3 = `VARB_XFER_US3,
  parameter integer XFER_US4 = `VARB_XFER_US4,
  parameter integer XFER_US5 = `VARB_XFER_US5,
  parameter integer XFER_US6 = `VARB_XFER_US6,
  parameter integer XFER_US7 = `VARB_XFER_US7,
  parameter integer IACK_LONG_CYC = `VARB_IACK_LONG_CYC,
  parameter integer IACK_SHORT_CYC = `VARB_IACK_SHORT_CYC
) (
  input wire core_clk,
  input wire nrst,
  input wire busTimerDisable,
  input wire [2:0] transferTimeoutSelect,
  input wire iackTimeoutSelect,
  input wire strobeActive,
  input wire slaveAck,
  input wire iackCycle,
  output reg busErrorDrive
);

  // =====================================================
  // Limit lookup
  function [`VARB_TMR_W-1:0] xferLimit;
    input [2:0] sel;
    reg [31:0] full;
    begin
      case (sel)
        3'h0: full = XFER_US0 * CLK_MHZ;
        3'h1: full = XFER_US1 * CLK_MHZ;
        3'h2: full = XFER_US2 * CLK_MHZ;
        3'h3: full = XFER_US3 * CLK_MHZ;
        3'h4: full = XFER_US4 * CLK_MHZ;
        3'h5: full = XFER_US5 * CLK_MHZ;
        3'h6: full = XFER_US6 * CLK_MHZ;
        default: full = XFER_US7 * CLK_MHZ;
      endcase
      // The counter width must cover the longest count in the table
      xferLimit = full[`VARB_TMR_W-1:0];
    end
  endfunction

  localparam [31:0] IACK_SHORT_FULL = IACK_SHORT_CYC;
  localparam [31:0] IACK_LONG_FULL = IACK_LONG_CYC;

  wire [`VARB_TMR_W-1:0] limitVal;
  wire [`VARB_TMR_W-1:0] iackShort;
  wire [`VARB_TMR_W-1:0] iackLong;
  assign iackShort = IACK_SHORT_FULL[`VARB_TMR_W-1:0];
  assign iackLong = IACK_LONG_FULL[`VARB_TMR_W-1:0];
  assign limitVal = iackCycle ? (iackTimeoutSelect ? iackShort : iackLong)
                              : xferLimit(transferTimeoutSelect);

  // =====================================================
  // Counter
  reg [`VARB_TMR_W-1:0] count_reg;
  wire running;
  assign running = !busTimerDisable && strobeActive && !slaveAck;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= {`VARB_TMR_W{1'b0}};
      busErrorDrive <= 1'b0;
    end else if (!running) begin
      // Strobes gone or ack seen: stop and release the error line
      count_reg <= {`VARB_TMR_W{1'b0}};
      busErrorDrive <= 1'b0;
    end else if (count_reg >= limitVal - 1'b1) begin
      busErrorDrive <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

endmodule
`default_nettype wire

// File: verilog/varb_arbiter.v
// Four-level bus arbiter with bus-clear generation, indicators and bus timer
// Summary of operation
// - Bus clear asks the owner to release; the owner decides when.
// - Fixed mode: level 3 highest, then 2, 1, 0.
// - Fixed mode: free bus goes to highest pending level.
// - Fixed mode: bus clear when a higher level than owner requests.
// - Rotation mode: all four levels have equal preference.
// - Rotation mode: bus clear on any pending request.
// - Top-plus-rotation: level 3 first, levels 2..0 rotate equally.
// - Top-plus-rotation: bus clear when level 3 requests on owned bus.
// - Default mode is top-plus-rotation.
// - Bus clear driven only when its drive enable is set.
// - Four owner level indicators; all off when bus is unowned.
// - Bus-free indicator while unowned; bus-clear indicator while asserted.
// - No fairness guarantee; starvation is allowed.
// - Bus timer drives bus error low on slave timeout.
// - Eight transfer timeouts chosen by a three-bit select.
// - Interrupt acknowledge cycles use an independent two-value timeout.
// - After reset timer controls are high and timer disabled.
// - Iack select 0 gives 128us, 1 gives 32us.
// - Timer disable 0 enables, 1 disables; reset state disabled.
// - Four-level request, grant, busy handshake with daisy-chained grants.
`timescale 1ns/10ps
`default_nettype none
`include "varb_consts.vh"
module varb_arbiter (
  input wire core_clk,
  input wire nrst,
  input wire arbiterEnableConfig,
  input wire [1:0] arbitrationTypeConfig,
  input wire clearDriveEnable,
  input wire [3:0] busRequest,
  input wire busBusy,
  output wire [3:0] busGrantOut,
  output wire [3:0] busGrantOe,
  output wire busClearOut,
  output wire busClearOe,
  output reg [3:0] ownerLevelIndicator,
  output reg busFreeIndicator,
  output reg busClearIndicator,
  input wire busTimerDisable,
  input wire [2:0] transferTimeoutSelect,
  input wire iackTimeoutSelect,
  input wire strobeActive,
  input wire slaveAck,
  input wire iackCycle,
  output wire busErrorOut,
  output wire busErrorOe
);

  // =====================================================
  // State machine
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_GRANT = 2'h1;
  localparam [1:0] ST_OWNED = 2'h2;
  localparam [1:0] ST_RELEASE = 2'h3;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] grant_reg;
  reg [3:0] grant_next;
  reg [1:0] owner_reg;
  reg [1:0] owner_next;
  reg [1:0] rotPtr_reg;
  reg [1:0] rotPtr_next;
  reg [1:0] mode_reg;
  reg clear_reg;
  reg clearNext;
  reg pickValid;
  reg [1:0] pickLevel;

  // =====================================================
  // Selection helpers
  // Highest pending level among the requests
  function [2:0] highest;
    input [3:0] req;
    begin
      if (req[3]) highest = 3'h7;
      else if (req[2]) highest = 3'h6;
      else if (req[1]) highest = 3'h5;
      else if (req[0]) highest = 3'h4;
      else highest = 3'h0;
    end
  endfunction

  // First pending level at or after ptr, wrapping within the mask
  function [2:0] rotPick;
    input [3:0] req;
    input [1:0] ptr;
    input [3:0] mask;
    reg [2:0] res;
    reg [1:0] idx;
    integer k;
    begin
      res = 3'h0;
      for (k = 3; k >= 0; k = k - 1) begin
        idx = ptr + k[1:0];
        if (req[idx] && mask[idx]) res = {1'b1, idx};
      end
      rotPick = res;
    end
  endfunction

  // Mode is sampled once after reset: it is a static strap
  reg modeCaught_reg;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= `VARB_MODE_DEFAULT;
      modeCaught_reg <= 1'b0;
    end else if (!modeCaught_reg) begin
      mode_reg <= (arbitrationTypeConfig == 2'h3) ? `VARB_MODE_DEFAULT
                                                  : arbitrationTypeConfig;
      modeCaught_reg <= 1'b1;
    end
  end

  always @* begin
    pickValid = 1'b0;
    pickLevel = 2'h0;
    case (mode_reg)
      `VARB_MODE_FIXED: begin
        {pickValid, pickLevel} = highest(busRequest);
      end
      `VARB_MODE_ROTATE: begin
        {pickValid, pickLevel} = rotPick(busRequest, rotPtr_reg, 4'hF);
      end
      default: begin
        if (busRequest[3]) begin
          pickValid = 1'b1;
          pickLevel = 2'h3;
        end else begin
          {pickValid, pickLevel} = rotPick(busRequest, rotPtr_reg, 4'h7);
        end
      end
    endcase
  end

  // =====================================================
  // Grant handshake
  always @* begin
    state_next = state_reg;
    grant_next = grant_reg;
    owner_next = owner_reg;
    rotPtr_next = rotPtr_reg;
    case (state_reg)
      ST_IDLE: begin
        // Wait for busy to drop so a new grant never overlaps an owner
        if (pickValid && !busBusy && arbiterEnableConfig) begin
          grant_next = 4'h1 << pickLevel;
          owner_next = pickLevel;
          if (pickLevel != 2'h3 || mode_reg == `VARB_MODE_ROTATE) begin
            rotPtr_next = pickLevel + 2'h1;
            if (mode_reg == `VARB_MODE_TOPROT && pickLevel == 2'h2) begin
              rotPtr_next = 2'h0;
            end
          end
          state_next = ST_GRANT;
        end
      end
      ST_GRANT: begin
        // Grant stands until a master on the chain takes busy
        if (busBusy) begin
          grant_next = 4'h0;
          state_next = ST_OWNED;
        end else if (busRequest[owner_reg] == 1'b0) begin
          // Requester withdrew before taking the bus
          grant_next = 4'h0;
          state_next = ST_IDLE;
        end
      end
      ST_OWNED: begin
        if (!busBusy) begin
          state_next = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // =====================================================
  // Bus clear generation
  always @* begin
    clearNext = 1'b0;
    if (state_reg == ST_OWNED) begin
      case (mode_reg)
        `VARB_MODE_FIXED: clearNext = (highest(busRequest) > {1'b1, owner_reg});
        `VARB_MODE_ROTATE: clearNext = |busRequest;
        default: clearNext = busRequest[3];
      endcase
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      grant_reg <= 4'h0;
      owner_reg <= 2'h0;
      rotPtr_reg <= 2'h0;
      clear_reg <= 1'b0;
      ownerLevelIndicator <= 4'h0;
      busFreeIndicator <= 1'b1;
      busClearIndicator <= 1'b0;
    end else begin
      state_reg <= state_next;
      grant_reg <= grant_next;
      owner_reg <= owner_next;
      rotPtr_reg <= rotPtr_next;
      // Only a request; the owner keeps the bus as long as it likes
      clear_reg <= clearNext;
      busClearIndicator <= clearNext;
      // Free as soon as busy is gone, including the release cycle
      busFreeIndicator <= (state_next != ST_OWNED);
      ownerLevelIndicator <= (state_next == ST_OWNED) ? (4'h1 << owner_next)
                                                      : 4'h0;
    end
  end

  // Grant lines released entirely when the arbiter is off (not slot one)
  assign busGrantOut = grant_reg;
  assign busGrantOe = arbiterEnableConfig ? 4'hF : 4'h0;

  // Open drain: pull low only while clear is active and drive is allowed
  assign busClearOut = 1'b0;
  assign busClearOe = clear_reg & clearDriveEnable;

  // =====================================================
  // Bus timer
  // No fairness tracking beyond the rotation pointer; starvation possible
  wire busErrorDrive;
  varb_bus_timer timerInst (
    .core_clk(core_clk),
    .nrst(nrst),
    .busTimerDisable(busTimerDisable),
    .transferTimeoutSelect(transferTimeoutSelect),
    .iackTimeoutSelect(iackTimeoutSelect),
    .strobeActive(strobeActive),
    .slaveAck(slaveAck),
    .iackCycle(iackCycle),
    .busErrorDrive(busErrorDrive)
  );

  assign busErrorOut = 1'b0;
  assign busErrorOe = busErrorDrive;

endmodule
`default_nettype wire

// File: sim/varb_arbiter_assertions.sv
// Concurrent checks on the arbiter and bus timer ports
`timescale 1ns/10ps
`default_nettype none
`include "varb_consts.vh"
module varb_arbiter_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic arbiterEnableConfig,
  input wire logic [1:0] arbitrationTypeConfig,
  input wire logic [3:0] busRequest,
  input wire logic busBusy,
  input wire logic [3:0] busGrantOut,
  input wire logic [3:0] busGrantOe,
  input wire logic [3:0] ownerLevelIndicator,
  input wire logic busFreeIndicator,
  input wire logic busClearIndicator,
  input wire logic busTimerDisable,
  input wire logic strobeActive,
  input wire logic busErrorOe
);
  // ==========================================
  // Properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  property p_grantOff; !arbiterEnableConfig |-> busGrantOe == 4'h0; endproperty
  a_grantOff: assert property (p_grantOff) else $error("grant driven when off");
  property p_busyNoGrant; busBusy |=> busGrantOut == 4'h0; endproperty
  a_busyNoGrant: assert property (p_busyNoGrant) else $error("grant while busy");
  property p_grantCause;
    $rose(|busGrantOut) |-> |(busGrantOut & $past(busRequest)) && !$past(busBusy);
  endproperty
  a_grantCause: assert property (p_grantCause) else $error("grant without cause");
  property p_owned;
    busBusy [*3] |-> $onehot(ownerLevelIndicator) && !busFreeIndicator;
  endproperty
  a_owned: assert property (p_owned) else $error("owned indicators wrong");
  property p_idle;
    (!busBusy) [*4] |-> ownerLevelIndicator == 4'h0 && busFreeIndicator;
  endproperty
  a_idle: assert property (p_idle) else $error("idle indicators wrong");
  // Eight quiet cycles; clear is re-evaluated every cycle and falls one cycle after level 3 stops requesting
  property p_topClear;
    (arbitrationTypeConfig == `VARB_MODE_TOPROT && !busRequest[3]) [*8] |-> !busClearIndicator;
  endproperty
  a_topClear: assert property (p_topClear) else $error("clear without top request");
  property p_timerOff; busTimerDisable [*2] |-> !busErrorOe; endproperty
  a_timerOff: assert property (p_timerOff) else $error("error while timer off");
  property p_errorDrop; (!strobeActive) [*2] |-> !busErrorOe; endproperty
  a_errorDrop: assert property (p_errorDrop) else $error("error without strobe");
endmodule
bind varb_arbiter varb_arbiter_checker u_chk (
  .core_clk, .nrst, .arbiterEnableConfig, .arbitrationTypeConfig, .busRequest, .busBusy,
  .busGrantOut, .busGrantOe, .ownerLevelIndicator, .busFreeIndicator, .busClearIndicator,
  .busTimerDisable, .strobeActive, .busErrorOe
);
`default_nettype wire

// File: sim/varb_master_model.sv
// Behavioural bus masters on the four request levels
`timescale 1ns/10ps
`default_nettype none
module varb_master_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] busGrantOut,
  input wire logic [3:0] newRequest,
  output logic [3:0] busRequest,
  output logic busBusy,
  output logic [3:0] lastGrant
);
  // ==========================================
  // Masters
  logic [7:0] holdCnt;
  // Owner keeps the bus 30 cycles whatever clear says, then leaves
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busRequest <= 4'h0;
      busBusy <= 1'b0;
      lastGrant <= 4'h0;
      holdCnt <= 8'h00;
    end else if (busBusy) begin
      busRequest <= busRequest | newRequest;
      holdCnt <= holdCnt - 8'h01;
      if (holdCnt == 8'h00) busBusy <= 1'b0;
    end else begin
      // Only a requesting level takes a grant and answers with busy
      busRequest <= (busRequest | newRequest) & ~(busGrantOut & busRequest);
      if (|(busGrantOut & busRequest)) begin
        busBusy <= 1'b1;
        holdCnt <= 8'h1D;
        lastGrant <= busGrantOut;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/vme_four_level_arbiter_bus_timer_test.sv
// Self-checking bench for the four-level arbiter and bus timer
`timescale 1ns/10ps
`default_nettype none
`include "varb_consts.vh"
module vme_four_level_arbiter_bus_timer_test;
  // ==========================================
  // Stimulus and checks
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic arbiterEnableConfig = 1'b1;
  logic [1:0] arbitrationTypeConfig = `VARB_MODE_DEFAULT;
  logic clearDriveEnable = 1'b1;
  logic busTimerDisable = 1'b1;
  logic [2:0] transferTimeoutSelect = 3'h7;
  logic iackTimeoutSelect = 1'b1;
  logic strobeActive = 1'b0;
  logic slaveAck = 1'b0;
  logic iackCycle = 1'b0;
  logic [3:0] newRequest = 4'h0;
  logic [3:0] busRequest, busGrantOut, busGrantOe, ownerLevelIndicator, lastGrant;
  logic busBusy, busClearOe, busFreeIndicator, busClearIndicator, busErrorOe;
  logic busClearOut, busErrorOut;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  initial forever #2 core_clk = ~core_clk;
  varb_arbiter u_dut (.core_clk, .nrst, .arbiterEnableConfig, .arbitrationTypeConfig,
    .clearDriveEnable, .busRequest, .busBusy, .busGrantOut, .busGrantOe, .busClearOut,
    .busClearOe, .ownerLevelIndicator, .busFreeIndicator, .busClearIndicator,
    .busTimerDisable, .transferTimeoutSelect, .iackTimeoutSelect, .strobeActive,
    .slaveAck, .iackCycle, .busErrorOut, .busErrorOe);
  varb_master_model u_masters (.core_clk, .nrst, .busGrantOut, .newRequest, .busRequest,
    .busBusy, .lastGrant);
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Run is about 27000 cycles; a hang is cut off well beyond that
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic cmp(input string what, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(input logic [3:0] r);
    newRequest = r;
    step(1);
    newRequest = 4'h0;
  endtask
  task automatic restart(input logic [1:0] m, input logic e);
    nrst = 1'b0;
    arbitrationTypeConfig = m;
    arbiterEnableConfig = e;
    step(12);
    nrst = 1'b1;
    step(2);
  endtask
  task automatic grant(input logic [3:0] g);
    int n;
    n = 0;
    while (busBusy !== 1'b0 && n < 300) begin step(1); n++; end
    while (busBusy !== 1'b1 && n < 300) begin step(1); n++; end
    cmp("grant level", g, lastGrant);
  endtask
  // Owner holds g1 while a second and then a level 3 request arrive
  task automatic arbitrate(input logic [1:0] m, input logic [3:0] p1, input logic [3:0] g1,
      input logic [3:0] pA, input logic clrA, input logic [3:0] g2, input logic [3:0] g3,
      input logic c);
    clearDriveEnable = c;
    restart(m, 1'b1);
    pulse(p1);
    grant(g1);
    step(3);
    cmp("grant enable", 4'hF, busGrantOe);
    cmp("owner level", g1, ownerLevelIndicator);
    cmp("bus free", 4'h0, {3'h0, busFreeIndicator});
    pulse(pA);
    step(6);
    cmp("bus clear", {3'h0, clrA}, {3'h0, busClearIndicator});
    pulse(4'h8);
    step(6);
    cmp("bus clear", 4'h1, {3'h0, busClearIndicator});
    cmp("clear drive", {3'h0, c}, {3'h0, busClearOe});
    cmp("clear level", 4'h0, {3'h0, busClearOut});
    grant(g2);
    grant(g3);
    step(40);
    cmp("owner level", 4'h0, ownerLevelIndicator);
    cmp("bus free", 4'h1, {3'h0, busFreeIndicator});
  endtask
  task automatic expire(input int lim);
    int n;
    n = 0;
    step(lim - 6);
    cmp("early bus error", 4'h0, {3'h0, busErrorOe});
    while (busErrorOe !== 1'b1 && n < 12) begin step(1); n++; end
    cmp("bus error", 4'h1, {3'h0, busErrorOe});
    cmp("bus error level", 4'h0, {3'h0, busErrorOut});
    strobeActive = 1'b0;
    step(2);
    cmp("bus error", 4'h0, {3'h0, busErrorOe});
  endtask
  initial begin
    restart(`VARB_MODE_FIXED, 1'b0);
    pulse(4'h1);
    step(8);
    cmp("grant enable", 4'h0, busGrantOe);
    cmp("grant", 4'h0, busGrantOut);
    arbitrate(`VARB_MODE_FIXED, 4'h5, 4'h4, 4'h1, 1'b0, 4'h8, 4'h1, 1'b1);
    arbitrate(`VARB_MODE_ROTATE, 4'h8, 4'h8, 4'h1, 1'b1, 4'h1, 4'h8, 1'b0);
    arbitrate(`VARB_MODE_DEFAULT, 4'h4, 4'h4, 4'h2, 1'b0, 4'h8, 4'h2, 1'b1);
    strobeActive = 1'b1;
    step(2100);
    cmp("disabled bus error", 4'h0, {3'h0, busErrorOe});
    strobeActive = 1'b0;
    busTimerDisable = 1'b0;
    transferTimeoutSelect = 3'h0;
    step(1);
    strobeActive = 1'b1;
    expire(`VARB_XFER_US0 * `VARB_CLK_MHZ);
    strobeActive = 1'b1;
    step(100);
    slaveAck = 1'b1;
    step(2100);
    cmp("acked bus error", 4'h0, {3'h0, busErrorOe});
    strobeActive = 1'b0;
    slaveAck = 1'b0;
    transferTimeoutSelect = 3'h1;
    step(1);
    strobeActive = 1'b1;
    expire(`VARB_XFER_US1 * `VARB_CLK_MHZ);
    iackCycle = 1'b1;
    strobeActive = 1'b1;
    expire(`VARB_IACK_SHORT_CYC);
    iackTimeoutSelect = 1'b0;
    strobeActive = 1'b1;
    step(`VARB_IACK_SHORT_CYC + 100);
    cmp("long iack bus error", 4'h0, {3'h0, busErrorOe});
    strobeActive = 1'b0;
    step(2);
    report_and_stop();
  end
endmodule
`default_nettype wire
